// >>> rtl/io_ports.v
// Notes on behaviour
// - Port A at 70H, per-pin direction at 35H.
// - Direction 0: input, read returns pin.
// - Direction 1: drive latch, read returns latch.
// - Writes to ports A-D always update latch.
// - Reset clears port A direction and latch.
// - Port B at 71H, group direction 24H bit0.
// - Reset clears port B direction and latch.
// - Port C at 72H, per-pin direction at 34H.
// - Analog select at 23H routes C to comparator.
// - Analog pins still latch writes, read by direction.
// - Reset clears port C direction, select, latch.
// - Port D at 73H, direction 33H, reset clears.
// - D direction to input keeps latch value.
// - Serial enable 0AH hands D0-D2 to serial.
// - Timer select 12H switches D3 to timer.
// - Timer pin set on reset, toggles on match.
// - Port D alternate-mode read sources per pin.
// - Serial shifting overwrites serial-output latch bit unless port D is written that cycle.
// - Port E two pins at 6FH, direction 32H.
// - Port E reads always return pin levels.
// - Port E bits 2,3 ignore writes, read 0.
// - Reset clears port E direction and latch.
// - Reference select moves E1 to reference input.
`include "io_ports_regs.vh"
module io_ports (
    input wire CLK,
    input wire NRST,
    input wire [7:0] ADDR,
    input wire RF_SEL,
    input wire [3:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [3:0] RDATA,
    input wire [3:0] PA_IN,
    output wire [3:0] PA_OUT,
    output wire [3:0] PA_OE,
    input wire [3:0] PB_IN,
    output wire [3:0] PB_OUT,
    output wire [3:0] PB_OE,
    input wire [3:0] PC_IN,
    output wire [3:0] PC_OUT,
    output wire [3:0] PC_OE,
    output wire [3:0] PC_ANALOG,
    input wire [3:0] PD_IN,
    output wire [3:0] PD_OUT,
    output wire [3:0] PD_OE,
    input wire [1:0] PE_IN,
    output wire [1:0] PE_OUT,
    output wire [1:0] PE_OE,
    output wire PE1_VREF,
    input wire HAS_CMP,
    input wire SIO_INT_CLK,
    input wire SIO_SCK_OUT,
    input wire SIO_SO,
    input wire SIO_SO_LOAD,
    input wire TIMER_RESET,
    input wire TIMER_MATCH,
    output wire SIO_ENABLE,
    output wire SIO_SCK_IN,
    output wire SIO_SI,
    output wire TIMER_OUT_ENABLE
);

////////////////////////////////////////////////////////////////////////////////
// Pin input synchronisers, three stages, change accepted when 2 and 3 agree
wire [17:0] pin_raw = {PE_IN, PD_IN, PC_IN, PB_IN, PA_IN};
reg [17:0] s1_q;
reg [17:0] s2_q;
reg [17:0] s3_q;
reg [17:0] pin_q;
genvar gi;
generate
    for (gi = 0; gi < 18; gi = gi + 1) begin : g_sync
        always @(posedge CLK or negedge NRST) begin
            if (!NRST) begin
                s1_q[gi] <= 1'b0;
                s2_q[gi] <= 1'b0;
                s3_q[gi] <= 1'b0;
                pin_q[gi] <= 1'b0;
            end else begin
                s1_q[gi] <= pin_raw[gi];
                s2_q[gi] <= s1_q[gi];
                s3_q[gi] <= s2_q[gi];
                if (s2_q[gi] == s3_q[gi]) begin
                    pin_q[gi] <= s3_q[gi];
                end
            end
        end
    end
endgenerate
wire [3:0] pa_pin = pin_q[3:0];
wire [3:0] pb_pin = pin_q[7:4];
wire [3:0] pc_pin = pin_q[11:8];
wire [3:0] pd_pin = pin_q[15:12];
wire [1:0] pe_pin = pin_q[17:16];

////////////////////////////////////////////////////////////////////////////////
// Control and latch registers
reg [3:0] pa_dir_q;
reg pb_dir_q;
reg [3:0] pc_dir_q;
reg [3:0] pc_ana_q;
reg [3:0] pd_dir_q;
reg [1:0] pe_dir_q;
reg sio_en_q;
reg tmo_sel_q;
reg [3:0] cmp_ref_q;
reg [3:0] pa_lat_q;
reg [3:0] pb_lat_q;
reg [3:0] pc_lat_q;
reg [3:0] pd_lat_q;
reg [1:0] pe_lat_q;
reg tmo_q;

wire rf_wr = WR && RF_SEL;
wire dm_wr = WR && !RF_SEL;

always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        pa_dir_q <= `RST_NIBBLE;
        pb_dir_q <= 1'b0;
        pc_dir_q <= `RST_NIBBLE;
        pc_ana_q <= `RST_NIBBLE;
        pd_dir_q <= `RST_NIBBLE;
        pe_dir_q <= `RST_PORT_E;
        sio_en_q <= 1'b0;
        tmo_sel_q <= 1'b0;
        cmp_ref_q <= `RST_NIBBLE;
    end else if (rf_wr) begin
        case (ADDR)
            `RF_PORT_A_DIR: pa_dir_q <= WDATA;
            `RF_PORT_B_GROUP: pb_dir_q <= WDATA[`BIT_GROUP_DIR];
            `RF_PORT_C_DIR: pc_dir_q <= WDATA;
            `RF_PORT_C_ANALOG: pc_ana_q <= WDATA & {4{HAS_CMP}};
            `RF_PORT_D_DIR: pd_dir_q <= WDATA;
            `RF_PORT_E_DIR: pe_dir_q <= WDATA[1:0];
            `RF_SERIAL_ENABLE: sio_en_q <= WDATA[`BIT_SERIAL_EN];
            `RF_TIMER_OUT_SEL: tmo_sel_q <= WDATA[`BIT_TIMER_SEL];
            `RF_CMP_REF_SEL: cmp_ref_q <= WDATA;
            default: ;
        endcase
    end
end

// Data latches; port D latch is untouched by direction changes
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        pa_lat_q <= `RST_NIBBLE;
        pb_lat_q <= `RST_NIBBLE;
        pc_lat_q <= `RST_NIBBLE;
        pd_lat_q <= `RST_NIBBLE;
        pe_lat_q <= `RST_PORT_E;
    end else begin
        if (dm_wr && ADDR == `ADDR_PORT_A_DATA) begin
            pa_lat_q <= WDATA;
        end
        if (dm_wr && ADDR == `ADDR_PORT_B_DATA) begin
            pb_lat_q <= WDATA;
        end
        if (dm_wr && ADDR == `ADDR_PORT_C_DATA) begin
            pc_lat_q <= WDATA;
        end
        if (dm_wr && ADDR == `ADDR_PORT_D_DATA) begin
            pd_lat_q <= WDATA;
        end else if (sio_en_q && SIO_SO_LOAD) begin
            pd_lat_q[`BIT_SO] <= SIO_SO;
        end
        if (dm_wr && ADDR == `ADDR_PORT_E_DATA) begin
            pe_lat_q <= WDATA[1:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Timer toggle output
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        tmo_q <= 1'b1;
    end else if (TIMER_RESET) begin
        tmo_q <= 1'b1;
    end else if (TIMER_MATCH) begin
        tmo_q <= ~tmo_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin drive
assign PA_OUT = pa_lat_q;
assign PA_OE = pa_dir_q;
assign PB_OUT = pb_lat_q;
assign PB_OE = {4{pb_dir_q}};
assign PC_OUT = pc_lat_q;
assign PC_OE = pc_dir_q;
assign PC_ANALOG = pc_ana_q;

// Port D: serial owns bits 0-2, timer owns bit 3 when selected
wire sck_drive = sio_en_q && SIO_INT_CLK;
wire [3:0] pd_drv;
assign pd_drv[`BIT_SCK] = sio_en_q ? SIO_SCK_OUT : pd_lat_q[`BIT_SCK];
assign pd_drv[`BIT_SO] = sio_en_q ? SIO_SO : pd_lat_q[`BIT_SO];
assign pd_drv[`BIT_SI] = pd_lat_q[`BIT_SI];
assign pd_drv[`BIT_TMO] = tmo_sel_q ? tmo_q : pd_lat_q[`BIT_TMO];
wire [3:0] pd_oe;
assign pd_oe[`BIT_SCK] = sio_en_q ? sck_drive : pd_dir_q[`BIT_SCK];
assign pd_oe[`BIT_SO] = sio_en_q ? 1'b1 : pd_dir_q[`BIT_SO];
assign pd_oe[`BIT_SI] = sio_en_q ? 1'b0 : pd_dir_q[`BIT_SI];
assign pd_oe[`BIT_TMO] = tmo_sel_q ? 1'b1 : pd_dir_q[`BIT_TMO];
// Open drain: only a low level is driven
assign PD_OUT = 4'h0;
assign PD_OE = pd_oe & ~pd_drv;
assign SIO_ENABLE = sio_en_q;
assign SIO_SCK_IN = pd_pin[`BIT_SCK];
assign SIO_SI = pd_pin[`BIT_SI];
assign TIMER_OUT_ENABLE = tmo_sel_q;

// Port E, open drain; E1 released when used as reference input
wire vref_sel = HAS_CMP && (cmp_ref_q != `RST_NIBBLE);
assign PE1_VREF = vref_sel;
wire [1:0] pe_oe = pe_dir_q & ~pe_lat_q;
assign PE_OUT = 2'h0;
assign PE_OE = {pe_oe[1] & ~vref_sel, pe_oe[0]};

////////////////////////////////////////////////////////////////////////////////
// Read path, data one cycle after the strobe
wire [3:0] pd_std = (pd_dir_q & pd_lat_q) | (~pd_dir_q & pd_pin);
reg [3:0] pd_rd;
always @* begin
    pd_rd = pd_std;
    if (sio_en_q) begin
        pd_rd[`BIT_SCK] = SIO_INT_CLK ? pd_lat_q[`BIT_SCK] : pd_pin[`BIT_SCK];
        pd_rd[`BIT_SO] = 1'b0;
        pd_rd[`BIT_SI] = pd_pin[`BIT_SI];
    end
    if (tmo_sel_q) begin
        pd_rd[`BIT_TMO] = pd_lat_q[`BIT_TMO];
    end
end

reg [3:0] rd_d;
always @* begin
    rd_d = 4'h0;
    if (RF_SEL) begin
        case (ADDR)
            `RF_PORT_A_DIR: rd_d = pa_dir_q;
            `RF_PORT_B_GROUP: rd_d = {3'h0, pb_dir_q};
            `RF_PORT_C_DIR: rd_d = pc_dir_q;
            `RF_PORT_C_ANALOG: rd_d = pc_ana_q;
            `RF_PORT_D_DIR: rd_d = pd_dir_q;
            `RF_PORT_E_DIR: rd_d = {2'h0, pe_dir_q};
            `RF_SERIAL_ENABLE: rd_d = {3'h0, sio_en_q};
            `RF_TIMER_OUT_SEL: rd_d = {3'h0, tmo_sel_q};
            `RF_CMP_REF_SEL: rd_d = cmp_ref_q;
            default: rd_d = 4'h0;
        endcase
    end else begin
        case (ADDR)
            `ADDR_PORT_A_DATA: rd_d = (pa_dir_q & pa_lat_q) | (~pa_dir_q & pa_pin);
            `ADDR_PORT_B_DATA: rd_d = pb_dir_q ? pb_lat_q : pb_pin;
            `ADDR_PORT_C_DATA: rd_d = (pc_dir_q & pc_lat_q) | (~pc_dir_q & pc_pin);
            `ADDR_PORT_D_DATA: rd_d = pd_rd;
            `ADDR_PORT_E_DATA: rd_d = {2'h0, pe_pin};
            default: rd_d = 4'h0;
        endcase
    end
end

always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        RDATA <= 4'h0;
    end else if (RD) begin
        RDATA <= rd_d;
    end else begin
        RDATA <= 4'h0;
    end
end

endmodule

// >>> rtl/io_ports_regs.vh
`ifndef IO_PORTS_REGS_VH
`define IO_PORTS_REGS_VH
// Data-memory addresses (bank 0)
`define ADDR_PORT_E_DATA 8'h6f
`define ADDR_PORT_A_DATA 8'h70
`define ADDR_PORT_B_DATA 8'h71
`define ADDR_PORT_C_DATA 8'h72
`define ADDR_PORT_D_DATA 8'h73
// Register-file addresses
`define RF_SERIAL_ENABLE 8'h0a
`define RF_TIMER_OUT_SEL 8'h12
`define RF_PORT_C_ANALOG 8'h23
`define RF_PORT_B_GROUP 8'h24
`define RF_PORT_E_DIR 8'h32
`define RF_PORT_D_DIR 8'h33
`define RF_PORT_C_DIR 8'h34
`define RF_PORT_A_DIR 8'h35
// Extra control word, placed in a free register-file slot
`define RF_CMP_REF_SEL 8'h3f
// Field positions
`define BIT_GROUP_DIR 0
`define BIT_SERIAL_EN 0
`define BIT_TIMER_SEL 0
`define BIT_SCK 0
`define BIT_SO 1
`define BIT_SI 2
`define BIT_TMO 3
`define BIT_VREF 1
// Reset values
`define RST_NIBBLE 4'h0
`define RST_PORT_E 2'h0
`endif

// >>> verif/io_ports_assertions.sv
module io_ports_chk (
    input wire CLK,
    input wire NRST,
    input wire [7:0] ADDR,
    input wire RF_SEL,
    input wire [3:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [3:0] RDATA,
    input wire [3:0] PA_OUT,
    input wire [3:0] PA_OE,
    input wire [3:0] PB_OE,
    input wire [3:0] PC_OE,
    input wire [3:0] PC_ANALOG,
    input wire HAS_CMP
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    wire rfw = WR && RF_SEL;
    wire dmw = WR && !RF_SEL;
    ////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 4'h0)
        else $error("read data not idle");
    reset_clear_a: assert property ($rose(NRST) |-> PA_OE == 4'h0 && PA_OUT == 4'h0
        && PB_OE == 4'h0 && PC_OE == 4'h0) else $error("reset state wrong");
    pa_dir_a: assert property (rfw && ADDR == 8'h35 |=> PA_OE == $past(WDATA))
        else $error("port a direction wrong");
    pa_latch_a: assert property (dmw && ADDR == 8'h70 |=> PA_OUT == $past(WDATA))
        else $error("port a latch wrong");
    pa_hold_a: assert property (!(rfw && ADDR == 8'h35) |=> $stable(PA_OE))
        else $error("port a direction moved");
    pb_group_a: assert property (rfw && ADDR == 8'h24 && WDATA[0] |=> PB_OE == 4'hf)
        else $error("port b group wrong");
    pc_dir_a: assert property (rfw && ADDR == 8'h34 |=> PC_OE == $past(WDATA))
        else $error("port c direction wrong");
    pc_analog_a: assert property (rfw && ADDR == 8'h23 && HAS_CMP |=>
        PC_ANALOG == $past(WDATA)) else $error("analog select wrong");
    pe_upper_a: assert property (RD && !RF_SEL && ADDR == 8'h6f |=> RDATA[3:2] == 2'h0)
        else $error("port e upper bits set");
    pa_rdlatch_a: assert property (RD && !RF_SEL && ADDR == 8'h70 && PA_OE == 4'hf
        |=> RDATA == $past(PA_OUT)) else $error("port a latch read wrong");
endmodule

// >>> verif/pin_board.sv
module pin_board (
    input wire [3:0] ext,
    input wire [3:0] pa_out,
    input wire [3:0] pa_oe,
    input wire [3:0] pb_out,
    input wire [3:0] pb_oe,
    input wire [3:0] pc_out,
    input wire [3:0] pc_oe,
    input wire [3:0] pd_oe,
    input wire [1:0] pe_oe,
    output wire [3:0] pa_in,
    output wire [3:0] pb_in,
    output wire [3:0] pc_in,
    output wire [3:0] pd_in,
    output wire [1:0] pe_in
);
    // Push-pull pins follow the driver, else the board level
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext);
    assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext);
    // Open-drain pins pull low when enabled, else pull-up or board low
    assign pd_in = ~pd_oe & ext;
    assign pe_in = ~pe_oe & ext[1:0];
endmodule

// >>> verif/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic RF_SEL = 1'b0;
    logic [3:0] WDATA = 4'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic TIMER_RESET = 1'b0;
    logic TIMER_MATCH = 1'b0;
    logic [3:0] ext = 4'hf;
    wire [3:0] RDATA, PA_IN, PA_OUT, PA_OE, PB_IN, PB_OUT, PB_OE, PC_IN, PC_OUT, PC_OE;
    wire [3:0] PD_IN, PD_OE;
    wire [1:0] PE_IN, PE_OE;
    wire SIO_ENABLE, SIO_SI, TIMER_OUT_ENABLE, PE1_VREF;
    int fail_count = 0;
    int cmp_count = 0;
    int i;
    logic [7:0] dat [4] = '{8'h70, 8'h71, 8'h72, 8'h73};
    logic [7:0] dir [4] = '{8'h35, 8'h24, 8'h34, 8'h33};
    logic [7:0] rfa [6] = '{8'h23, 8'h24, 8'h32, 8'h33, 8'h34, 8'h35};
    logic [3:0] rfm [6] = '{4'hf, 4'h1, 4'h3, 4'hf, 4'hf, 4'hf};
    io_ports io_ports_inst (.CLK, .NRST, .ADDR, .RF_SEL, .WDATA, .WR, .RD, .RDATA,
        .PA_IN, .PA_OUT, .PA_OE, .PB_IN, .PB_OUT, .PB_OE, .PC_IN, .PC_OUT, .PC_OE,
        .PC_ANALOG(), .PD_IN, .PD_OUT(), .PD_OE, .PE_IN, .PE_OUT(), .PE_OE, .PE1_VREF,
        .HAS_CMP(1'b1), .SIO_INT_CLK(1'b0), .SIO_SCK_OUT(1'b0), .SIO_SO(1'b0),
        .SIO_SO_LOAD(1'b0), .TIMER_RESET, .TIMER_MATCH, .SIO_ENABLE, .SIO_SCK_IN(),
        .SIO_SI, .TIMER_OUT_ENABLE);
    pin_board pin_board_inst (.ext(ext), .pa_out(PA_OUT), .pa_oe(PA_OE), .pb_out(PB_OUT),
        .pb_oe(PB_OE), .pc_out(PC_OUT), .pc_oe(PC_OE), .pd_oe(PD_OE), .pe_oe(PE_OE),
        .pa_in(PA_IN), .pb_in(PB_IN), .pc_in(PC_IN), .pd_in(PD_IN), .pe_in(PE_IN));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [3:0] got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic rf, input logic [7:0] a, input logic [3:0] d);
        @(posedge CLK);
        RF_SEL <= rf;
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task rd(input logic rf, input logic [7:0] a, input logic [3:0] exp);
        @(posedge CLK);
        RF_SEL <= rf;
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        chk(RDATA, exp);
    endtask
    task tick(input logic m);
        @(posedge CLK);
        TIMER_MATCH <= m;
        TIMER_RESET <= !m;
        @(posedge CLK);
        TIMER_MATCH <= 1'b0;
        TIMER_RESET <= 1'b0;
        repeat (2) @(negedge CLK);
    endtask
    task finish_test;
        $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 CLK = ~CLK;
    end
    initial begin
        repeat (50000) @(posedge CLK);
        fail_count++;
        finish_test;
    end
    initial begin
        repeat (4) @(posedge CLK);
        NRST <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rd(1'b1, rfa[i], 4'h0);
            wr(1'b1, rfa[i], 4'hf);
            rd(1'b1, rfa[i], rfm[i]);
            wr(1'b1, rfa[i], 4'h0);
        end
        wr(1'b0, 8'h74, 4'hf);
        rd(1'b0, 8'h74, 4'h0);
        rd(1'b0, 8'h6f, 4'h3);
        for (i = 0; i < 4; i++) begin
            ext <= 4'h9;
            wr(1'b1, dir[i], 4'hf);
            rd(1'b0, dat[i], 4'h0);
            wr(1'b1, dir[i], 4'h0);
            wr(1'b0, dat[i], 4'h6);
            repeat (6) @(posedge CLK);
            rd(1'b0, dat[i], 4'h9);
            wr(1'b1, dir[i], 4'hf);
            rd(1'b0, dat[i], 4'h6);
            wr(1'b1, dir[i], 4'h0);
            repeat (6) @(posedge CLK);
            rd(1'b0, dat[i], 4'h9);
            wr(1'b1, dir[i], 4'hf);
            rd(1'b0, dat[i], 4'h6);
        end
        wr(1'b1, 8'h32, 4'h3);
        @(negedge CLK);
        chk({2'h0, PE_OE}, 4'h3);
        wr(1'b0, 8'h6f, 4'hf);
        ext <= 4'h2;
        repeat (6) @(posedge CLK);
        rd(1'b0, 8'h6f, 4'h2);
        wr(1'b1, 8'h12, 4'h1);
        tick(1'b0);
        chk({3'h0, PD_OE[3]}, 4'h0);
        tick(1'b1);
        chk({3'h0, PD_OE[3]}, 4'h1);
        chk({3'h0, TIMER_OUT_ENABLE}, 4'h1);
        wr(1'b1, 8'h0a, 4'h1);
        ext <= 4'h4;
        repeat (6) @(posedge CLK);
        chk({3'h0, SIO_ENABLE}, 4'h1);
        chk({3'h0, SIO_SI}, 4'h1);
        rd(1'b0, 8'h73, 4'h4);
        wr(1'b1, 8'h3f, 4'h1);
        @(negedge CLK);
        chk({3'h0, PE1_VREF}, 4'h1);
        finish_test;
    end
endmodule
bind io_ports io_ports_chk io_ports_chk_inst (.CLK, .NRST, .ADDR, .RF_SEL, .WDATA, .WR,
    .RD, .RDATA, .PA_OUT, .PA_OE, .PB_OE, .PC_OE, .PC_ANALOG, .HAS_CMP);
